// [timer_irq_pkg.sv]
package timer_irq_pkg;

  // ---------------------------------------------------------------------
  // register map: one 4 KiB page per timer, low 12 bits pick the register
  // ---------------------------------------------------------------------
  localparam logic [31:0] TMR1_BASE     = 32'h4000_E000; // timer 1 page
  localparam logic [31:0] TMR2_BASE     = 32'h4000_F000; // timer 2 page
  localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;       // control_one
  localparam logic [11:0] OFS_FLAG      = 12'h100;       // flag register
  localparam logic [11:0] OFS_MASK      = 12'h104;       // irq mask
  localparam logic [11:0] OFS_MISS      = 12'h108;       // missed events
  localparam logic [11:0] OFS_CAPVAL    = 12'h110;       // capture value
  localparam logic [11:0] OFS_IRQ_SET   = 12'h200;       // enable set
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h204;       // enable clear
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h208;       // enable state

  // ---------------------------------------------------------------------
  // control_one fields and reset value
  // ---------------------------------------------------------------------
  localparam int          CR_RUN_BIT    = 0;  // counter_run
  localparam int          CR_UINH_BIT   = 1;  // update_inhibit
  localparam int          CR_USRC_BIT   = 2;  // update_source_sel
  localparam int          CR_SHOT_BIT   = 3;  // single_shot_sel
  localparam int          CR_DIR_BIT    = 4;  // count_direction
  localparam int          CR_ALN_LSB    = 5;  // count_alignment_sel lsb
  localparam int          CR_ARB_BIT    = 7;  // reload_buffer_en
  localparam logic [7:0]  CR_RESET      = 8'h00;

  // ---------------------------------------------------------------------
  // flag register layout: bit0 update, bit1..4 channels, bit6 trigger
  // ---------------------------------------------------------------------
  localparam int          FL_UPD_BIT    = 0;
  localparam int          FL_CH_LSB     = 1;
  localparam int          FL_TRG_BIT    = 6;
  localparam logic [6:0]  FL_RESET      = 7'h00;

  // alignment modes
  localparam logic [1:0]  ALN_EDGE      = 2'b00;
  localparam logic [1:0]  ALN_DOWN      = 2'b01;
  localparam logic [1:0]  ALN_UP        = 2'b10;
  localparam logic [1:0]  ALN_BOTH      = 2'b11;

  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

endpackage : timer_irq_pkg

// [timer_irq_ctrl.sv]
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer_irq_ctrl
  import timer_irq_pkg::*;
#(
  parameter int NCH = 4                       // channels per timer
) (
  input  wire logic            CLK_SYS,       // 40 MHz clock
  input  wire logic            NRST,          // async reset, low
  input  wire logic [31:0]     AWADDR,        // write address
  input  wire logic            AWVALID,       // write address valid
  output logic                 AWREADY,       // write address ready
  input  wire logic [31:0]     WDATA,         // write data
  input  wire logic [3:0]      WSTRB,         // byte strobes
  input  wire logic            WVALID,        // write data valid
  output logic                 WREADY,        // write data ready
  output logic [1:0]           BRESP,         // write response
  output logic                 BVALID,        // write response valid
  input  wire logic            BREADY,        // write response ready
  input  wire logic [31:0]     ARADDR,        // read address
  input  wire logic            ARVALID,       // read address valid
  output logic                 ARREADY,       // read address ready
  output logic [31:0]          RDATA,         // read data
  output logic [1:0]           RRESP,         // read response
  output logic                 RVALID,        // read data valid
  input  wire logic            RREADY,        // read data ready
  input  wire logic [1:0]      TRIG_IN,       // trigger input per timer
  input  wire logic [1:0]      GATED_MODE,    // slave in gated mode
  input  wire logic [1:0]      TRIG_MODE,     // slave in trigger mode
  input  wire logic [1:0]      UPD_OVF,       // overflow/underflow
  input  wire logic [1:0]      UPD_SW,        // software update request
  input  wire logic [1:0]      UPD_SLV,       // slave controller reset
  input  wire logic [2*NCH-1:0] CH_EVENT,     // capture/compare events
  input  wire logic [2*NCH-1:0] CH_IS_CAP,    // channel in capture mode
  input  wire logic [1:0]      COUNT_DOWN,    // counter now counting down
  input  wire logic [2*NCH*16-1:0] CAP_VAL,   // capture values
  output logic [1:0]           IRQ,           // interrupt per timer
  output logic [1:0]           CNT_RUN,       // counter enable
  output logic [1:0]           CNT_DOWN_SEL,  // edge mode direction
  output logic [3:0]           CNT_ALIGN,     // alignment per timer
  output logic [1:0]           RELOAD_SHADOW, // buffered reload select
  output logic [1:0]           UPD_EVENT,     // shadow load update
  output logic [1:0]           CNT_REINIT     // counter/prescaler reinit
);

  // elaboration check: the flag layout has room for four channels only
  if (NCH != 4) begin : g_nch_check
    $error("flag layout serves exactly four channels");
  end

  // ---------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------
  // timer select: 0,1 for valid pages, 2 for unmapped
  function automatic logic [1:0] tsel(input logic [31:0] a);
    if (a[31:12] == TMR1_BASE[31:12]) tsel = 2'd0;
    else if (a[31:12] == TMR2_BASE[31:12]) tsel = 2'd1;
    else tsel = 2'd2;
  endfunction : tsel

  // compare flag allowed by alignment and direction
  function automatic logic cmp_ok(input logic [1:0] aln, input logic dn);
    if (aln == ALN_DOWN) cmp_ok = dn;
    else if (aln == ALN_UP) cmp_ok = !dn;
    else cmp_ok = 1'b1;
  endfunction : cmp_ok

  // ---------------------------------------------------------------------
  // input synchronisers for the trigger pins
  // ---------------------------------------------------------------------
  logic [1:0] trig_s1;   // first stage, read only by trig_s2
  logic [1:0] trig_s2;   // synchronised trigger
  logic [1:0] trig_d;    // delayed for edge detection
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      trig_s1 <= 2'b00;
      trig_s2 <= 2'b00;
      trig_d  <= 2'b00;
    end else begin
      trig_s1 <= TRIG_IN;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
    end
  end

  // ---------------------------------------------------------------------
  // axi4-lite handshake state
  // ---------------------------------------------------------------------
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [31:0] aw_addr, w_data, next_aw_addr, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_go, rd_go;     // register access this cycle
  logic [1:0]  wr_t, rd_t;       // decoded timer
  logic [11:0] wr_o, rd_o;       // page offsets

  // ---------------------------------------------------------------------
  // per-timer state
  // ---------------------------------------------------------------------
  logic [7:0] ctrl      [2];    // control_one
  logic [6:0] flags     [2];    // timer_flag_register
  logic [6:0] mask      [2];    // timer_irq_mask
  logic [NCH-1:0] miss  [2];    // missed_event_register
  logic [1:0] irq_en;           // timer_irq_bit enables
  logic [7:0] next_ctrl [2];
  logic [6:0] next_flags[2];
  logic [6:0] next_mask [2];
  logic [NCH-1:0] next_miss[2];
  logic [1:0] next_irq_en, next_irq, next_upd, next_reinit;

  // write and read decode shared by both timers
  assign wr_go = aw_held && w_held && !BVALID;
  assign wr_t  = tsel(aw_addr);
  assign wr_o  = aw_addr[11:0];
  assign rd_go = ARVALID && ARREADY;
  assign rd_t  = tsel(ARADDR);
  assign rd_o  = ARADDR[11:0];

  // ---------------------------------------------------------------------
  // bus next-state: one write and one read in flight at a time
  // ---------------------------------------------------------------------
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = BVALID;
    next_bresp   = BRESP;
    next_rvalid  = RVALID;
    next_rresp   = RRESP;
    next_rdata   = RDATA;
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_t == 2'd2) ? RESP_SLVERR : RESP_OKAY;
    end else if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end
    // accept a new half only while that half is empty
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (rd_t == 2'd2) begin
        next_rresp = RESP_SLVERR;     // unmapped page
      end else if (rd_o == OFS_CTRL_ONE) begin
        next_rdata[7:0] = ctrl[rd_t[0]];
      end else if (rd_o == OFS_FLAG) begin
        next_rdata[6:0] = flags[rd_t[0]];
      end else if (rd_o == OFS_MASK) begin
        next_rdata[6:0] = mask[rd_t[0]];
      end else if (rd_o == OFS_MISS) begin
        next_rdata[NCH-1:0] = miss[rd_t[0]];
      end else if (rd_o >= OFS_CAPVAL && rd_o < OFS_CAPVAL + 12'h010) begin
        next_rdata[15:0] = CAP_VAL[{rd_t[0], rd_o[3:2]}*16 +: 16];
      end else if (rd_o == OFS_IRQ_STAT) begin
        next_rdata[0] = irq_en[rd_t[0]];
      end else if (rd_o != OFS_IRQ_SET && rd_o != OFS_IRQ_CLR) begin
        next_rresp = RESP_SLVERR;     // hole inside the page
      end
    end else if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // ---------------------------------------------------------------------
  // per-timer next-state: flags, missed bits, control and enables
  // ---------------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      logic        wr_me;
      logic        rd_me;
      logic        upd_any;
      logic        upd_flag;
      logic [6:0]  set_v;
      logic [6:0]  clr_v;
      logic [NCH-1:0] ch_set;
      logic [NCH-1:0] miss_clr;
      logic        trg_edge;
      wr_me    = wr_go && (wr_t == 2'(t)) && strb_ok(w_strb);
      rd_me    = rd_go && (rd_t == 2'(t));
      next_ctrl[t]   = ctrl[t];
      next_mask[t]   = mask[t];
      next_irq_en[t] = irq_en[t];
      // inhibit blocks every update cause
      upd_any  = !ctrl[t][CR_UINH_BIT] &&
                 (UPD_OVF[t] || UPD_SW[t] || UPD_SLV[t]);
      // flag cause narrowed by update source select
      upd_flag = upd_any && (!ctrl[t][CR_USRC_BIT] || UPD_OVF[t]);
      // trigger edge: rising, or either edge in gated mode
      trg_edge = GATED_MODE[t] ? (trig_s2[t] ^ trig_d[t])
                               : (trig_s2[t] && !trig_d[t]);
      for (int c = 0; c < NCH; c++) begin
        ch_set[c] = CH_EVENT[t*NCH+c] &&
                    (CH_IS_CAP[t*NCH+c] ||
                     cmp_ok(ctrl[t][CR_ALN_LSB+:2], COUNT_DOWN[t]));
      end
      set_v = 7'h00;
      set_v[FL_UPD_BIT] = upd_flag;
      set_v[FL_CH_LSB+:NCH] = ch_set;
      set_v[FL_TRG_BIT] = trg_edge;
      clr_v = 7'h00;
      miss_clr = '0;
      if (wr_me && wr_o == OFS_FLAG) clr_v = w_data[6:0];
      // reading a capture value clears that channel's flag if it is in capture mode
      for (int c = 0; c < NCH; c++) begin
        if (rd_me && rd_o == OFS_CAPVAL + 12'(4*c) &&
            CH_IS_CAP[t*NCH+c])
          clr_v[FL_CH_LSB+c] = 1'b1;
      end
      if (wr_me && wr_o == OFS_MISS) miss_clr = w_data[NCH-1:0];
      // set beats a simultaneous clear
      next_flags[t] = (flags[t] & ~clr_v) | set_v;
      next_miss[t]  = (miss[t] & ~miss_clr) |
                      (ch_set & flags[t][FL_CH_LSB+:NCH]);
      if (wr_me && wr_o == OFS_CTRL_ONE) next_ctrl[t] = w_data[7:0];
      if (wr_me && wr_o == OFS_MASK) next_mask[t] = w_data[6:0];
      if (wr_me && wr_o == OFS_IRQ_SET && w_data[0])
        next_irq_en[t] = 1'b1;
      if (wr_me && wr_o == OFS_IRQ_CLR && w_data[0])
        next_irq_en[t] = 1'b0;
      // trigger mode starts the counter from hardware
      if (TRIG_MODE[t] && trg_edge)
        next_ctrl[t][CR_RUN_BIT] = 1'b1;
      // single shot stops at the update event
      if (upd_any && ctrl[t][CR_SHOT_BIT])
        next_ctrl[t][CR_RUN_BIT] = 1'b0;
      next_upd[t]    = upd_any;
      next_reinit[t] = UPD_SW[t] || UPD_SLV[t];
      // masked flags still latch; only the irq is gated
      next_irq[t] = next_irq_en[t] &&
                    |(next_flags[t] & next_mask[t]);
    end
  end

  // only WSTRB[0] is checked; writes without it are accepted but ignored
  function automatic logic strb_ok(input logic [3:0] s);
    strb_ok = s[0];
  endfunction : strb_ok

  // ---------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      ARREADY <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
      RVALID  <= 1'b0;
      RRESP   <= RESP_OKAY;
      RDATA   <= 32'h0000_0000;
      irq_en  <= 2'b00;
      IRQ     <= 2'b00;
      UPD_EVENT  <= 2'b00;
      CNT_REINIT <= 2'b00;
      for (int t = 0; t < 2; t++) begin
        ctrl[t]  <= CR_RESET;
        flags[t] <= FL_RESET;
        mask[t]  <= FL_RESET;
        miss[t]  <= '0;
      end
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      AWREADY <= next_awready;
      WREADY  <= next_wready;
      ARREADY <= next_arready;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
      RVALID  <= next_rvalid;
      RRESP   <= next_rresp;
      RDATA   <= next_rdata;
      irq_en  <= next_irq_en;
      IRQ     <= next_irq;
      UPD_EVENT  <= next_upd;
      CNT_REINIT <= next_reinit;
      for (int t = 0; t < 2; t++) begin
        ctrl[t]  <= next_ctrl[t];
        flags[t] <= next_flags[t];
        mask[t]  <= next_mask[t];
        miss[t]  <= next_miss[t];
      end
    end
  end

  // ---------------------------------------------------------------------
  // counter control outputs, copies of control_one bits
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      CNT_RUN       <= 2'b00;
      CNT_DOWN_SEL  <= 2'b00;
      CNT_ALIGN     <= 4'h0;
      RELOAD_SHADOW <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        CNT_RUN[t]       <= next_ctrl[t][CR_RUN_BIT];
        CNT_DOWN_SEL[t]  <= next_ctrl[t][CR_DIR_BIT];
        CNT_ALIGN[2*t+:2] <= next_ctrl[t][CR_ALN_LSB+:2];
        RELOAD_SHADOW[t] <= next_ctrl[t][CR_ARB_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  chk_irq_from_flags: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    IRQ[0] == (irq_en[0] && |(flags[0] & mask[0])))
    else $error("irq does not match masked flags");
  chk_irq_or_all: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    IRQ[1] == (irq_en[1] && |(flags[1] & mask[1])))
    else $error("timer 2 irq mismatch");
  chk_trig_sets_flag: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (!GATED_MODE[0] && trig_s2[0] && !trig_d[0]) |=> flags[0][FL_TRG_BIT])
    else $error("trigger edge did not set flag");
  chk_update_flag: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (UPD_OVF[0] && !ctrl[0][CR_UINH_BIT]) |=> flags[0][FL_UPD_BIT])
    else $error("overflow did not set update flag");
  chk_inhibit_update: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    ctrl[0][CR_UINH_BIT] |=> !UPD_EVENT[0])
    else $error("update event while inhibited");
  // timer 2 here: the bench writes zero over a set update flag there
  chk_zero_keeps_flag: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (wr_go && wr_t == 2'd1 && wr_o == OFS_FLAG && flags[1][0] && !w_data[0])
      |=> flags[1][0])
    else $error("zero write cleared a flag");
  chk_missed_mark: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (CH_EVENT[1] && CH_IS_CAP[1] && flags[0][FL_CH_LSB+1]) |=> miss[0][1])
    else $error("missed capture not recorded");
  chk_single_shot: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (UPD_OVF[0] && !ctrl[0][CR_UINH_BIT] && ctrl[0][CR_SHOT_BIT])
      |=> !ctrl[0][CR_RUN_BIT] ##1 !CNT_RUN[0])
    else $error("single shot did not stop counter");
  chk_enable_set: assert property (
    @(posedge CLK_SYS) disable iff (!NRST)
    (wr_go && wr_t == 2'd1 && wr_o == OFS_IRQ_SET && w_data[0] && w_strb[0])
      |=> irq_en[1])
    else $error("irq enable set ignored");

endmodule : timer_irq_ctrl

// [timer_irq_ctrl_test.sv]
`timescale 1ns/1ps
module timer_irq_ctrl_test
  import timer_irq_pkg::*;
;
  // ---------------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------------
  logic              CLK_SYS, NRST;             // clock, reset low
  logic [31:0]       AWADDR, WDATA, ARADDR;     // bus payloads
  logic              AWVALID, WVALID, ARVALID;  // request strobes
  logic              BREADY, RREADY;            // held high always
  logic              AWREADY, WREADY, ARREADY;  // slave readies
  logic [1:0]        BRESP, RRESP;              // responses
  logic              BVALID, RVALID;            // response strobes
  logic [31:0]       RDATA;                     // read data
  logic [3:0]        WSTRB;                     // byte strobes
  logic [1:0]        TRIG_IN, GATED_MODE, TRIG_MODE, COUNT_DOWN;
  logic [1:0]        UPD_OVF, UPD_SW, UPD_SLV;  // update causes
  logic [7:0]        CH_EVENT, CH_IS_CAP;       // channel events, modes
  logic [127:0]      CAP_VAL;                   // capture values
  logic [1:0]        IRQ, CNT_RUN, CNT_DOWN_SEL, RELOAD_SHADOW;
  logic [1:0]        UPD_EVENT, CNT_REINIT, ue, ri;
  logic [3:0]        CNT_ALIGN;                 // alignment mirror
  logic [31:0]       d;                         // last read data
  logic [1:0]        r, b;                      // last read, write resp
  int                errors, cmp_count;         // verdict counters

  timer_irq_ctrl #(.NCH(4)) u_dut (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .TRIG_IN(TRIG_IN), .GATED_MODE(GATED_MODE),
    .TRIG_MODE(TRIG_MODE), .UPD_OVF(UPD_OVF), .UPD_SW(UPD_SW),
    .UPD_SLV(UPD_SLV), .CH_EVENT(CH_EVENT), .CH_IS_CAP(CH_IS_CAP),
    .COUNT_DOWN(COUNT_DOWN), .CAP_VAL(CAP_VAL), .IRQ(IRQ), .CNT_RUN(CNT_RUN),
    .CNT_DOWN_SEL(CNT_DOWN_SEL), .CNT_ALIGN(CNT_ALIGN),
    .RELOAD_SHADOW(RELOAD_SHADOW), .UPD_EVENT(UPD_EVENT),
    .CNT_REINIT(CNT_REINIT));

  // ---------------------------------------------------------------------
  // helpers: every task starts and ends just after a rising edge
  // ---------------------------------------------------------------------
  always #12.5 CLK_SYS = ~CLK_SYS;               // 40 MHz

  function automatic logic [31:0] ad(input int t, input logic [11:0] o);
    return (t == 1 ? TMR2_BASE : TMR1_BASE) + 32'(o);
  endfunction : ad

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin                           // four-state compare
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    AWADDR  <= a;
    WDATA   <= v;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    b = BRESP;
  endtask : wr

  // read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [31:0] a);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    d = RDATA;
    r = RRESP;
  endtask : rd

  // one-cycle cause; outputs sampled at the edge after the response
  task automatic ev(input int k, input int i);
    case (k)
      0: UPD_OVF[i] <= 1'b1;
      1: UPD_SW[i] <= 1'b1;
      2: UPD_SLV[i] <= 1'b1;
      default: CH_EVENT[i] <= 1'b1;
    endcase
    @(posedge CLK_SYS);
    {UPD_OVF, UPD_SW, UPD_SLV, CH_EVENT} <= '0;
    @(posedge CLK_SYS);
    ue = UPD_EVENT;
    ri = CNT_REINIT;
  endtask : ev

  // trigger level change, then flag check and clear (sync latency 3)
  task automatic trg(input logic lv, input logic e);
    TRIG_IN[0] <= lv;
    repeat (6) @(posedge CLK_SYS);
    rd(ad(0, OFS_FLAG));
    chk("trigger flag", 32'(e), 32'(d[FL_TRG_BIT]));
    wr(ad(0, OFS_FLAG), 32'h0000_0040);
  endtask : trg

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #(25 * 20000);
    errors++;
    final_report();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {CLK_SYS, NRST, AWVALID, WVALID, ARVALID} = '0;
    {AWADDR, WDATA, ARADDR, TRIG_IN, GATED_MODE, TRIG_MODE} = '0;
    {UPD_OVF, UPD_SW, UPD_SLV, CH_EVENT, CH_IS_CAP, COUNT_DOWN} = '0;
    {BREADY, RREADY, WSTRB} = 6'h3F;
    {errors, cmp_count} = '0;
    CAP_VAL = {96'h0, 16'h1234, 16'h0000};      // timer1 channel1 value
    repeat (8) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    for (int t = 0; t < 2; t++) begin
      rd(ad(t, OFS_CTRL_ONE));
      chk("control reset", 32'(CR_RESET), d);
    end
    wr(ad(1, OFS_CTRL_ONE), 32'h0000_0090);     // buffered reload, down
    chk("write resp", 32'(RESP_OKAY), 32'(b));
    rd(ad(1, OFS_CTRL_ONE));
    chk("control rw", 32'h0000_0090, d);
    chk("reload shadow", 32'h1, 32'(RELOAD_SHADOW[1]));
    chk("down select", 32'h1, 32'(CNT_DOWN_SEL[1]));
    rd(32'h4000_D000);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    wr(32'h4000_D000, 32'h0000_0001);
    chk("unmapped wresp", 32'(RESP_SLVERR), 32'(b));
    $display("test registers done");
    // masked flag still records; irq needs mask and enable
    ev(0, 1);
    rd(ad(1, OFS_FLAG));
    chk("update flag", 32'h1, d);
    chk("irq masked", 32'h0, 32'(IRQ));
    wr(ad(1, OFS_MASK), 32'h0000_0001);
    wr(ad(1, OFS_IRQ_SET), 32'h0000_0001);
    chk("irq on", 32'h2, 32'(IRQ));
    wr(ad(1, OFS_IRQ_CLR), 32'h0000_0001);
    chk("irq off", 32'h0, 32'(IRQ));
    wr(ad(1, OFS_IRQ_SET), 32'h0000_0001);
    wr(ad(1, OFS_FLAG), 32'h0000_0000);
    chk("irq kept", 32'h2, 32'(IRQ));
    wr(ad(1, OFS_FLAG), 32'h0000_0001);
    chk("irq cleared", 32'h0, 32'(IRQ));
    $display("test interrupt done");
    // capture twice: missed bit; capture read clears flag
    CH_IS_CAP <= 8'h02;
    ev(3, 1);
    ev(3, 1);
    rd(ad(0, OFS_MISS));
    chk("missed set", 32'h2, d);
    wr(ad(0, OFS_MISS), 32'h0000_0000);
    rd(ad(0, OFS_MISS));
    chk("missed kept", 32'h2, d);
    wr(ad(0, OFS_MISS), 32'h0000_0002);
    rd(ad(0, OFS_MISS));
    chk("missed clear", 32'h0, d);
    rd(ad(0, OFS_CAPVAL + 12'h004));
    chk("capture value", 32'h0000_1234, d);
    rd(ad(0, OFS_FLAG));
    chk("capture flag", 32'h0, d);
    CH_IS_CAP <= 8'h00;
    $display("test capture done");
    // compare flags against alignment mode and direction
    for (int m = 0; m < 4; m++) begin
      for (int dn = 0; dn < 2; dn++) begin
        wr(ad(0, OFS_CTRL_ONE), 32'(m) << CR_ALN_LSB);
        COUNT_DOWN <= 2'(dn);
        ev(3, 0);
        rd(ad(0, OFS_FLAG));
        chk("align mirror", 32'(m), 32'(CNT_ALIGN[1:0]));
        chk("align flag", (m == 1) ? dn : (m == 2) ? 32'(!dn) : 1,
            32'(d[FL_CH_LSB]));
        wr(ad(0, OFS_FLAG), 32'h0000_00FF);
      end
    end
    $display("test alignment done");
    // update gating, source selection and single shot
    wr(ad(0, OFS_CTRL_ONE), 32'h0000_0002);     // inhibit
    ev(0, 0);
    chk("inhibit event", 32'h0, 32'(ue[0]));
    ev(1, 0);
    chk("inhibit reinit", 32'h1, 32'(ri[0]));
    rd(ad(0, OFS_FLAG));
    chk("inhibit flag", 32'h0, d);
    wr(ad(0, OFS_CTRL_ONE), 32'h0000_0004);     // overflow-only source
    ev(2, 0);
    rd(ad(0, OFS_FLAG));
    chk("source slave", 32'h0, d);
    ev(0, 0);
    rd(ad(0, OFS_FLAG));
    chk("source ovf", 32'h1, d);
    wr(ad(0, OFS_CTRL_ONE), 32'h0000_0009);     // single shot, run
    chk("run on", 32'h1, 32'(CNT_RUN[0]));
    ev(0, 0);
    repeat (2) @(posedge CLK_SYS);
    chk("shot stop", 32'h0, 32'(CNT_RUN[0]));
    $display("test update done");
    // trigger: rising edge, trigger mode start, gated both edges
    wr(ad(0, OFS_FLAG), 32'h0000_00FF);
    TRIG_MODE <= 2'b01;
    trg(1'b1, 1'b1);
    chk("trigger run", 32'h1, 32'(CNT_RUN[0]));
    TRIG_MODE <= 2'b00;
    trg(1'b0, 1'b0);
    GATED_MODE <= 2'b01;
    trg(1'b1, 1'b1);
    trg(1'b0, 1'b1);
    $display("test trigger done");
    final_report();
  end
endmodule : timer_irq_ctrl_test
